/* File: hw/modem_ctrl_pkg.sv */
//------------------------------------------------------------------------------
// Purpose: Shared constants and types of the modem control and status block
// Assumes: AHB-Lite register access, one word per register
// Notes:   Modem pins are active low; status bits show the active state as 1
//------------------------------------------------------------------------------
package modem_ctrl_pkg;

  // ----------------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------------
  localparam logic [7:0] DIV_LOW_OFFSET   = 8'h00;
  localparam logic [7:0] DIV_HIGH_OFFSET  = 8'h04;
  localparam logic [7:0] IRQ_ENABLE_OFFSET = 8'h08;
  localparam logic [7:0] CONTROL_OFFSET   = 8'h0C;
  localparam logic [7:0] STATUS_OFFSET    = 8'h10;

  // ----------------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------------
  localparam int MCR_TERM_READY_BIT = 0;
  localparam int MCR_REQ_SEND_BIT   = 1;
  localparam int MCR_OUT_ONE_BIT    = 2;
  localparam int MCR_OUT_TWO_BIT    = 3;
  localparam int MCR_LOOP_BIT       = 4;
  localparam int MCR_WIDTH          = 5;
  localparam int IER_MODEM_BIT      = 3;
  localparam int IER_WIDTH          = 4;
  localparam int MSR_CTS_CHG_BIT    = 0;
  localparam int MSR_DSR_CHG_BIT    = 1;
  localparam int MSR_RING_EDGE_BIT  = 2;
  localparam int MSR_DCD_CHG_BIT    = 3;
  localparam int MSR_LIVE_LSB       = 4;

  // ----------------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------------
  localparam logic [7:0]           DIV_LOW_RESET  = 8'h01;
  localparam logic [7:0]           DIV_HIGH_RESET = 8'h00;
  localparam logic [IER_WIDTH-1:0] IER_RESET      = 4'h0;
  localparam logic [MCR_WIDTH-1:0] MCR_RESET      = 5'h00;
  localparam logic [3:0]           PINS_IDLE      = 4'hF;

  // ----------------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------------
  // Modem pins, active low, order: carrier, ring, set ready, clear to send
  typedef struct packed {
    logic carrier_n;
    logic ring_n;
    logic set_ready_n;
    logic clear_to_send_n;
  } modem_in_s;

  // Modem outputs, active low
  typedef struct packed {
    logic general_output_two_n;
    logic general_output_one_n;
    logic request_to_send_n;
    logic terminal_ready_n;
  } modem_out_s;

  typedef struct packed {
    logic [1:0]           mr_sync;
    logic [3:0]           pin_s1;
    logic [3:0]           pin_s2;
    logic [3:0]           prev_active;
    logic [7:0]           div_low;
    logic [7:0]           div_high;
    logic [IER_WIDTH-1:0] interrupt_enable_reg;
    logic [MCR_WIDTH-1:0] modem_control_reg;
    logic [3:0]           flags;
    logic [15:0]          baud_cnt;
    logic                 baud_out;
    modem_out_s           mout;
    logic                 irq;
    logic                 ph_write;
    logic [7:0]           ph_addr;
    logic                 hreadyout;
    logic [31:0]          hrdata;
  } modem_state_s;

  localparam modem_state_s STATE_RESET = '{
    mr_sync:     2'b00,
    pin_s1:      PINS_IDLE,
    pin_s2:      PINS_IDLE,
    prev_active: 4'h0,
    div_low:     DIV_LOW_RESET,
    div_high:    DIV_HIGH_RESET,
    interrupt_enable_reg:         IER_RESET,
    modem_control_reg:         MCR_RESET,
    flags:       4'h0,
    baud_cnt:    16'h0000,
    baud_out:    1'b0,
    mout:        4'hF,
    irq:         1'b0,
    ph_write:    1'b0,
    ph_addr:     8'h00,
    hreadyout:   1'b1,
    hrdata:      32'h0000_0000
  };

endpackage : modem_ctrl_pkg

/* File: hw/modem_ctrl.sv */
//------------------------------------------------------------------------------
// Purpose: Modem handshake control, status and 16x baud clock with AHB-Lite
// Assumes: Modem pins and master reset asynchronous to hclk; hclk is the
//          reference oscillator for the baud divider
// Notes:   Zero wait state slave; reading status clears the change flags
//
// Overview of operation
// - Status bit 4 shows clear-to-send state
// - Clear-to-send change sets status bit 0
// - Clear-to-send ignored in loop mode
// - Status bit 5 shows data-set-ready state
// - Data-set-ready change sets status bit 1
// - Control bit 0 set drives terminal-ready low outside loop mode
// - Control bit 0 clear returns terminal-ready high
// - Master reset forces terminal-ready high
// - Control bit 1 set drives request-to-send low outside loop mode
// - Master reset forces request-to-send high
// - Baud clock equals oscillator over divisor for divisors of 2 and above; divisor 1 holds it high, divisor 0 low
// - Control bit 2 drives general output one
// - Master reset forces general output one high
// - Loop mode holds general output one high
// - Control bit 3 drives general output two
// - Master reset forces general output two high
// - Loop mode holds general output two high
// - Status bit 6 shows ring state
// - Ring pin rising sets status bit 2
// - Ring rise interrupts when enable bit 3
// - Ring sensing works with terminal-ready inactive
// - Status bits 7 and 3 for carrier
// - Carrier change interrupts when enabled
// - Master reset clears whole control register
//------------------------------------------------------------------------------
//
// The implementer's own choices: the AHB-Lite register port and the register addresses.
module modem_ctrl
  import modem_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  // AHB-Lite slave
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output      logic                     hreadyout,
  output      logic                     hresp,
  output      logic [31:0]              hrdata,
  // Modem side
  input  wire modem_ctrl_pkg::modem_in_s  modem_in,
  input  wire logic                     master_reset_in,
  output      modem_ctrl_pkg::modem_out_s modem_out,
  output      logic                     baud_clock_x16_out,
  output      logic                     interrupt_request
);
  import modem_ctrl_pkg::*;

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  function automatic logic [31:0] read_word(input modem_state_s s, input logic [7:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (a)
      DIV_LOW_OFFSET:    w[7:0]           = s.div_low;
      DIV_HIGH_OFFSET:   w[7:0]           = s.div_high;
      IRQ_ENABLE_OFFSET: w[IER_WIDTH-1:0] = s.interrupt_enable_reg;
      CONTROL_OFFSET:    w[MCR_WIDTH-1:0] = s.modem_control_reg;
      STATUS_OFFSET:     w[7:0]           = {s.prev_active, s.flags};
      default:           w                = 32'h0000_0000;
    endcase
    return w;
  endfunction : read_word

  function automatic logic is_status(input logic [7:0] a);
    return a == STATUS_OFFSET;
  endfunction : is_status

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  modem_state_s r;
  modem_state_s next_r;

  logic       addr_phase;
  logic       master_reset;
  logic       loop_mode;
  logic [3:0] pin_active;
  logic [3:0] live;
  logic [3:0] changed;
  logic [15:0] divisor;
  logic [7:0] addr_byte;

  assign addr_phase   = hsel && hready && htrans[1];
  assign master_reset = r.mr_sync[1];
  assign loop_mode    = r.modem_control_reg[MCR_LOOP_BIT];
  assign pin_active   = ~r.pin_s2;
  assign divisor      = {r.div_high, r.div_low};
  assign addr_byte    = {haddr[7:2], 2'b00};

  always_comb begin
    next_r = r;

    // --------------------------------------------------------------------------
    // Synchronisers
    // --------------------------------------------------------------------------
    next_r.mr_sync = {r.mr_sync[0], master_reset_in};
    next_r.pin_s1  = modem_in;
    next_r.pin_s2  = r.pin_s1;

    // --------------------------------------------------------------------------
    // Live modem state, loop mode feeds control bits back
    // --------------------------------------------------------------------------
    // loop replaces pins
    if (loop_mode) begin
      live = {r.modem_control_reg[MCR_OUT_TWO_BIT], r.modem_control_reg[MCR_OUT_ONE_BIT],
              r.modem_control_reg[MCR_TERM_READY_BIT], r.modem_control_reg[MCR_REQ_SEND_BIT]};
    end else begin
      live = pin_active;
    end
    next_r.prev_active = live;

    changed[MSR_CTS_CHG_BIT] = live[0] ^ r.prev_active[0];
    changed[MSR_DSR_CHG_BIT] = live[1] ^ r.prev_active[1];
    changed[MSR_RING_EDGE_BIT] = r.prev_active[2] && !live[2];
    changed[MSR_DCD_CHG_BIT] = live[3] ^ r.prev_active[3];

    // --------------------------------------------------------------------------
    // AHB-Lite data phase writes
    // --------------------------------------------------------------------------
    if (r.ph_write) begin
      unique case (r.ph_addr)
        DIV_LOW_OFFSET:    next_r.div_low  = hwdata[7:0];
        DIV_HIGH_OFFSET:   next_r.div_high = hwdata[7:0];
        IRQ_ENABLE_OFFSET: next_r.interrupt_enable_reg      = hwdata[IER_WIDTH-1:0];
        CONTROL_OFFSET:    next_r.modem_control_reg      = hwdata[MCR_WIDTH-1:0];
        default:           next_r.interrupt_enable_reg      = next_r.interrupt_enable_reg;
      endcase
    end

    // --------------------------------------------------------------------------
    // AHB-Lite address phase
    // --------------------------------------------------------------------------
    next_r.hreadyout = 1'b1;
    next_r.ph_write  = addr_phase && hwrite;
    next_r.ph_addr   = addr_byte;
    next_r.hrdata    = 32'h0000_0000;
    next_r.flags     = r.flags;
    if (addr_phase && !hwrite) begin
      next_r.hrdata = read_word(r, addr_byte);
      if (is_status(addr_byte)) begin
        next_r.flags = 4'h0;
      end
    end
    // New events win over the read clear
    next_r.flags = next_r.flags | changed;

    // --------------------------------------------------------------------------
    // Master reset
    // --------------------------------------------------------------------------
    if (master_reset) begin
      next_r.modem_control_reg   = MCR_RESET;
      next_r.flags = 4'h0;
    end

    // --------------------------------------------------------------------------
    // Modem outputs
    // --------------------------------------------------------------------------
    // terminal ready
    next_r.mout.terminal_ready_n = !(next_r.modem_control_reg[MCR_TERM_READY_BIT] &&
                                     !next_r.modem_control_reg[MCR_LOOP_BIT]);
    next_r.mout.request_to_send_n = !(next_r.modem_control_reg[MCR_REQ_SEND_BIT] &&
                                      !next_r.modem_control_reg[MCR_LOOP_BIT]);
    next_r.mout.general_output_one_n = !(next_r.modem_control_reg[MCR_OUT_ONE_BIT] &&
                                         !next_r.modem_control_reg[MCR_LOOP_BIT]);
    next_r.mout.general_output_two_n = !(next_r.modem_control_reg[MCR_OUT_TWO_BIT] &&
                                         !next_r.modem_control_reg[MCR_LOOP_BIT]);

    // --------------------------------------------------------------------------
    // Interrupt request
    // --------------------------------------------------------------------------
    // modem status interrupt
    next_r.irq = next_r.interrupt_enable_reg[IER_MODEM_BIT] && (next_r.flags != 4'h0);

    // --------------------------------------------------------------------------
    // Baud clock divider
    // --------------------------------------------------------------------------
    // divide by sixteen-bit divisor
    if (divisor == 16'h0000) begin
      next_r.baud_cnt = 16'h0000;
      next_r.baud_out = 1'b0;
    end else begin
      if (r.baud_cnt >= divisor - 16'h0001) begin
        next_r.baud_cnt = 16'h0000;
      end else begin
        next_r.baud_cnt = r.baud_cnt + 16'h0001;
      end
      next_r.baud_out = (next_r.baud_cnt >= {1'b0, divisor[15:1]});
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= STATE_RESET;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  assign hreadyout          = r.hreadyout;
  assign hresp              = 1'b0;
  assign hrdata             = r.hrdata;
  assign modem_out          = r.mout;
  assign baud_clock_x16_out = r.baud_out;
  assign interrupt_request  = r.irq;

endmodule : modem_ctrl

/* File: verif/modem_ctrl_checker.sv */
// Purpose: Port assertions for the modem control block
// Assumes: One clock domain; the block is the only bus slave
// Notes:   Bound to modem_ctrl from the bench top file
module modem_ctrl_checker
  import modem_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic                       hclk,
  input wire logic                       hresetn,
  // Bus
  input wire logic                       hsel,
  input wire logic [31:0]                haddr,
  input wire logic [1:0]                 htrans,
  input wire logic                       hwrite,
  input wire logic                       hready,
  input wire logic                       hreadyout,
  input wire logic                       hresp,
  input wire logic [31:0]                hrdata,
  // Modem side
  input wire modem_ctrl_pkg::modem_in_s  modem_in,
  input wire logic                       master_reset_in,
  input wire modem_ctrl_pkg::modem_out_s modem_out,
  input wire logic                       interrupt_request
);
  timeunit 1ns;
  timeprecision 1ps;

  logic       taken;
  logic       rd_dp;
  logic       wr_dp;
  logic [3:0] prev_in;
  logic [2:0] cnt_q;
  logic [2:0] cnt_w;

  assign taken = hsel && hready && htrans[1];

  // Cycles since a pin change and since a write landed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_dp   <= 1'b0;
      wr_dp   <= 1'b0;
      prev_in <= PINS_IDLE;
      cnt_q   <= 3'd7;
      cnt_w   <= 3'd7;
    end else begin
      rd_dp   <= taken && !hwrite;
      wr_dp   <= taken && hwrite;
      prev_in <= modem_in;
      cnt_q   <= (modem_in != prev_in) ? 3'd0 : cnt_q + {2'b0, cnt_q != 3'd7};
      cnt_w   <= (wr_dp && hready) ? 3'd0 : cnt_w + {2'b0, cnt_w != 3'd7};
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_mr_held;
    master_reset_in [*6];
  endsequence

  sequence s_quiet_status_read;
    taken && !hwrite && haddr[7:0] == STATUS_OFFSET && cnt_q >= 3'd4 && cnt_w >= 3'd3;
  endsequence

  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_rdata_idle: assert property (!rd_dp |-> hrdata == 32'h0)
    else $error("read data outside a read data phase");
  a_term_mreset: assert property (s_mr_held |-> modem_out.terminal_ready_n)
    else $error("terminal ready active under master reset");
  a_rts_mreset: assert property (s_mr_held |-> modem_out.request_to_send_n)
    else $error("request to send active under master reset");
  a_gp_mreset: assert property (s_mr_held |-> modem_out.general_output_one_n
    && modem_out.general_output_two_n)
    else $error("general output active under master reset");
  a_mcr_clear: assert property (s_mr_held |=> modem_out == 4'hF)
    else $error("outputs not idle after master reset");
  a_flag_clear: assert property (s_quiet_status_read |-> ##[1:2] !interrupt_request)
    else $error("status read left interrupt pending");
  a_irq_cause: assert property ($rose(interrupt_request) |-> cnt_q <= 3'd4 || cnt_w <= 3'd2)
    else $error("interrupt raised without pin change or write");
endmodule : modem_ctrl_checker

/* File: verif/modem_model.sv */
// Purpose: Modem side model driving the handshake pins
// Assumes: Pins active low, idle high
// Notes:   The bench picks which lines are active
module modem_model
  import modem_ctrl_pkg::*;
(
  // Clock
  input  wire logic                      hclk,
  // Bench control, 1 = line active
  input  wire logic [3:0]                act,
  // Modem pins
  output      modem_ctrl_pkg::modem_in_s modem_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // Pins idle until the first edge, then follow the bench request
  initial begin
    modem_in = PINS_IDLE;
    forever begin
      @(posedge hclk);
      modem_in <= ~act;
    end
  end
endmodule : modem_model

/* File: verif/tb_modem_ctrl.sv */
// Purpose: Self-checking bench for the modem control block
// Assumes: Zero wait state slave, hready taken from hreadyout
// Notes:   Tests are sequences of bus reads and writes
module tb_modem_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import modem_ctrl_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        mr;
  logic        baud;
  logic        last;
  logic        irq;
  logic [3:0]  act;
  logic [31:0] rv;
  modem_in_s   modem_in;
  modem_out_s  modem_out;
  int          n_fail;
  int          compares;
  int          rises;

  modem_ctrl modem_ctrl_inst (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .modem_in,
    .master_reset_in(mr), .modem_out, .baud_clock_x16_out(baud), .interrupt_request(irq));
  modem_model modem_model_inst (.hclk, .act, .modem_in);

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wait_rdy();
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
      if (i > 50) begin
        n_fail++;
        print_verdict();
      end
    end while (hreadyout !== 1'b1);
  endtask : wait_rdy

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    rv = hrdata;
  endtask : xfer

  task automatic step(input int n);
    repeat (n) @(posedge hclk);
  endtask : step

  initial begin
    hresetn = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    mr = 1'b0;
    act = 4'h0;
    n_fail = 0;
    compares = 0;
    step(16);
    hresetn <= 1'b1;
    step(1);
    xfer(1'b0, CONTROL_OFFSET, 32'h0);
    chk(rv, 32'h0, "control reset");
    xfer(1'b0, STATUS_OFFSET, 32'h0);
    chk(rv, 32'h0, "status reset");
    xfer(1'b0, 8'h20, 32'h0);
    chk(rv, 32'h0, "unmapped");
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, CONTROL_OFFSET, 32'h1 << i);
      step(1);
      chk({28'h0, modem_out}, {28'h0, ~(4'h1 << i)}, "out on");
      xfer(1'b1, CONTROL_OFFSET, 32'h0);
      step(1);
      chk({28'h0, modem_out}, 32'hF, "out off");
    end
    $display("test outputs done");
    xfer(1'b1, CONTROL_OFFSET, 32'h1D);
    act <= 4'h1;
    step(6);
    chk({28'h0, modem_out}, 32'hF, "loop out");
    xfer(1'b0, STATUS_OFFSET, 32'h0);
    chk(rv & 32'hF0, 32'hE0, "loop live");
    act <= 4'h0;
    xfer(1'b1, CONTROL_OFFSET, 32'h0);
    step(6);
    xfer(1'b0, STATUS_OFFSET, 32'h0);
    $display("test loop done");
    for (int i = 0; i < 4; i++) begin
      act <= 4'h1 << i;
      step(6);
      xfer(1'b0, STATUS_OFFSET, 32'h0);
      chk(rv, {24'h0, 4'h1 << i, (i == 2) ? 4'h0 : 4'h1 << i}, "pin on");
      act <= 4'h0;
      step(6);
      xfer(1'b0, STATUS_OFFSET, 32'h0);
      chk(rv, {28'h0, 4'h1 << i}, "pin off");
      xfer(1'b0, STATUS_OFFSET, 32'h0);
      chk(rv, 32'h0, "flags cleared");
    end
    $display("test status done");
    xfer(1'b1, IRQ_ENABLE_OFFSET, 32'h8);
    act <= 4'h4;
    step(6);
    chk({31'h0, irq}, 32'h0, "ring on irq");
    act <= 4'h0;
    step(6);
    chk({31'h0, irq}, 32'h1, "ring off irq");
    xfer(1'b0, STATUS_OFFSET, 32'h0);
    step(2);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    act <= 4'h8;
    step(6);
    chk({31'h0, irq}, 32'h1, "carrier irq");
    xfer(1'b0, STATUS_OFFSET, 32'h0);
    act <= 4'h0;
    step(6);
    xfer(1'b0, STATUS_OFFSET, 32'h0);
    $display("test interrupt done");
    xfer(1'b1, DIV_LOW_OFFSET, 32'h4);
    step(8);
    rises = 0;
    last = baud;
    repeat (64) begin
      @(posedge hclk);
      rises += int'(baud && !last);
      last = baud;
    end
    chk(rises, 32'd16, "baud rises");
    $display("test baud done");
    xfer(1'b1, CONTROL_OFFSET, 32'hF);
    act <= 4'h1;
    step(6);
    mr <= 1'b1;
    step(8);
    chk({28'h0, modem_out}, 32'hF, "mreset out");
    chk({31'h0, irq}, 32'h0, "mreset irq");
    mr <= 1'b0;
    step(4);
    xfer(1'b0, CONTROL_OFFSET, 32'h0);
    chk(rv, 32'h0, "mreset control");
    xfer(1'b0, STATUS_OFFSET, 32'h0);
    chk(rv, 32'h10, "mreset status");
    $display("test master reset done");
    print_verdict();
  end
endmodule : tb_modem_ctrl

bind modem_ctrl modem_ctrl_checker modem_ctrl_checker_inst (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata, .modem_in, .master_reset_in,
  .modem_out, .interrupt_request);
